//--- hw/scoc_params.svh
// constants for the stream configuration and overlay command logic
`ifndef SCOC_PARAMS_SVH
`define SCOC_PARAMS_SVH
`define SCOC_CMD_CFG_STREAM 8'h51
`define SCOC_CMD_OVERLAY 8'hB1
`define SCOC_SUB_RESTORE 8'hC0
`define SCOC_SUB_FREEZE 8'hC1
`define SCOC_SUB_IDENT 8'hC2
`define SCOC_SUB_SET 8'hC3
`define SCOC_FEAT_ADD_BIT 7
`define SCOC_FEAT_DIR_BIT 6
`define SCOC_DEV_SEL_BIT 4
`define SCOC_ST_BSY 7
`define SCOC_ST_RDY 6
`define SCOC_ST_DSC 4
`define SCOC_ST_DRQ 3
`define SCOC_ST_ERR 0
`define SCOC_ERR_ABORT 2
`define SCOC_NUM_STREAMS 8
`define SCOC_IDENT_WORDS 256
`define SCOC_OVL_REV 16'h0001
`define SCOC_OVL_SIG 8'hA5
`define SCOC_FULL_CAP 16'h01FF
`define SCOC_TIME_UNIT 16'h000A
`define SCOC_US_CYCLES 50
`endif

//--- hw/scoc_pkg.sv
// types shared by both ends of the command link
package scoc_pkg;
    typedef enum logic [3:0] {
        SCOC_IDLE = 4'h1,
        SCOC_EXEC = 4'h2,
        SCOC_XFER = 4'h4,
        SCOC_DONE = 4'h8
    } scoc_state_e;
    typedef struct packed {
        logic valid;
        logic is_write;
        logic [31:0] completion_time_limit_us;
        logic [15:0] alloc_unit;
    } scoc_stream_s;
endpackage

//--- hw/scoc_if.sv
// task-file link between host controller and drive
`timescale 1ns/1ns
interface scoc_if;
    logic cmd_wr;
    logic [7:0] command;
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic [7:0] dev_head;
    logic [7:0] status;
    logic [7:0] error;
    logic intrq;
    logic data_rd;
    logic [15:0] data;
    modport dev (input cmd_wr, command, feat_cur, feat_prev, count_cur, count_prev,
        dev_head, data_rd, output status, error, intrq, data);
    modport host (output cmd_wr, command, feat_cur, feat_prev, count_cur, count_prev,
        dev_head, data_rd, input status, error, intrq, data);
endinterface

//--- hw/scoc_completion_time_limit_timer.sv
// completion time limit counter, microsecond ticks
`timescale 1ns/1ns
`include "scoc_params.svh"
module scoc_completion_time_limit_timer
    import scoc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic stop,
    input wire logic [31:0] limit_us,
    output logic expired
);
    logic [5:0] tick_r;
    logic [31:0] us_r;
    logic run_r;
    always_ff @(posedge clk or posedge reset)
        if (reset)
            run_r <= 1'b0;
        else if (start)
            run_r <= 1'b1;
        else if (stop)
            run_r <= 1'b0;
    always_ff @(posedge clk or posedge reset)
        if (reset)
        begin
            tick_r <= 6'h00;
            us_r <= 32'h0;
        end
        else if (start)
        begin
            tick_r <= 6'h00;
            us_r <= 32'h0;
        end
        else if (run_r)
        begin
            if (tick_r == 6'(`SCOC_US_CYCLES - 1))
            begin
                tick_r <= 6'h00;
                us_r <= us_r + 32'h1;
            end
            else
                tick_r <= tick_r + 6'h01;
        end
    // zero limit means unlimited
    assign expired = run_r && (limit_us != 32'h0) && (us_r >= limit_us);
endmodule

//--- hw/scoc_drive.sv
// drive end: configure stream and configuration overlay commands
// ****************************************************************
// Notes on behaviour
// ****************************************************************
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`include "scoc_params.svh"
module scoc_drive
    import scoc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_n,
    input wire logic dev_is_slave,
    input wire logic stream_cmd,
    input wire logic [2:0] stream_cmd_id,
    input wire logic [31:0] stream_cmd_completion_time_limit,
    input wire logic stream_cmd_done,
    scoc_if.dev bus,
    output logic [15:0] active_cap,
    output logic [7:0] stream_valid,
    output logic [7:0] stream_is_write,
    output logic [15:0] alloc_unit,
    output logic completion_time_limit_expired
);
    // ****************************************************************
    // decode
    // ****************************************************************
    scoc_state_e state_r;
    scoc_stream_s streams_r [`SCOC_NUM_STREAMS];
    logic frozen_r;
    logic [15:0] set_cap_r;
    logic [7:0] status_r;
    logic [7:0] error_r;
    logic intrq_r;
    logic [15:0] data_r;
    logic [8:0] word_r;
    logic [7:0] csum_r;
    logic [7:0] cmd_r;
    logic [7:0] fcur_r;
    logic [7:0] fprev_r;
    logic [15:0] count_r;
    logic selected;
    logic abort_nxt;
    logic [2:0] sid;
    logic [31:0] limit_sel;
    logic [15:0] word_val;
    assign selected = bus.dev_head[`SCOC_DEV_SEL_BIT] == dev_is_slave;
    assign sid = fcur_r[2:0];
    always_comb
    begin
        abort_nxt = 1'b1;
        if (cmd_r == `SCOC_CMD_CFG_STREAM)
            abort_nxt = !fcur_r[`SCOC_FEAT_ADD_BIT] && !streams_r[sid].valid;
        else if (cmd_r == `SCOC_CMD_OVERLAY)
        begin
            case (fcur_r)
                `SCOC_SUB_RESTORE, `SCOC_SUB_FREEZE, `SCOC_SUB_IDENT:
                    abort_nxt = frozen_r;
                `SCOC_SUB_SET:
                    abort_nxt = frozen_r;
                default:
                    abort_nxt = 1'b1;
            endcase
        end
    end
    // ****************************************************************
    // command sequencer
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
        if (reset)
        begin
            cmd_r <= 8'h00;
            fcur_r <= 8'h00;
            fprev_r <= 8'h00;
            count_r <= 16'h0000;
        end
        else if (state_r == SCOC_IDLE && bus.cmd_wr && selected)
        begin
            cmd_r <= bus.command;
            fcur_r <= bus.feat_cur;
            fprev_r <= bus.feat_prev;
            count_r <= {bus.count_prev, bus.count_cur};
        end
    always_ff @(posedge clk or posedge reset)
        if (reset)
        begin
            state_r <= SCOC_IDLE;
            status_r <= 8'h00;
            error_r <= 8'h00;
            intrq_r <= 1'b0;
            word_r <= 9'h000;
        end
        else
        begin
            intrq_r <= 1'b0;
            case (state_r)
                SCOC_IDLE:
                begin
                    status_r[`SCOC_ST_RDY] <= 1'b1;
                    if (bus.cmd_wr && selected)
                    begin
                        status_r <= 8'h80;
                        state_r <= SCOC_EXEC;
                    end
                end
                SCOC_EXEC:
                begin
                    word_r <= 9'h000;
                    error_r <= 8'h00;
                    error_r[`SCOC_ERR_ABORT] <= abort_nxt;
                    if (!abort_nxt && cmd_r == `SCOC_CMD_OVERLAY && fcur_r == `SCOC_SUB_IDENT)
                    begin
                        status_r <= 8'h48;
                        intrq_r <= 1'b1;
                        state_r <= SCOC_XFER;
                    end
                    else
                    begin
                        status_r <= {1'b0, 1'b1, 1'b0, 1'b1, 3'b000, abort_nxt};
                        intrq_r <= 1'b1;
                        state_r <= SCOC_IDLE;
                    end
                end
                SCOC_XFER:
                    if (bus.data_rd)
                    begin
                        word_r <= word_r + 9'h001;
                        if (word_r == 9'(`SCOC_IDENT_WORDS - 1))
                        begin
                            status_r <= 8'h50;
                            state_r <= SCOC_IDLE;
                        end
                    end
                default:
                    state_r <= SCOC_IDLE;
            endcase
        end
    // ****************************************************************
    // stream table
    // ****************************************************************
    logic commit;
    assign commit = state_r == SCOC_EXEC && !abort_nxt;
    genvar g;
    generate
        for (g = 0; g < `SCOC_NUM_STREAMS; g++)
        begin : g_stream
            always_ff @(posedge clk or posedge reset)
                if (reset)
                    streams_r[g] <= '0;
                else if (commit && cmd_r == `SCOC_CMD_CFG_STREAM && sid == 3'(g))
                begin
                    streams_r[g].valid <= fcur_r[`SCOC_FEAT_ADD_BIT];
                    streams_r[g].is_write <= fcur_r[`SCOC_FEAT_DIR_BIT];
                    streams_r[g].completion_time_limit_us <= 32'(fprev_r) * 32'(`SCOC_TIME_UNIT);
                    streams_r[g].alloc_unit <= count_r;
                end
            assign stream_valid[g] = streams_r[g].valid;
            assign stream_is_write[g] = streams_r[g].is_write;
        end
    endgenerate
    assign alloc_unit = streams_r[stream_cmd_id].alloc_unit;
    // ****************************************************************
    // overlay state
    // ****************************************************************
    // power_on_n only: freeze must outlive hard and soft resets
    always_ff @(posedge clk or negedge power_on_n)
        if (!power_on_n)
            frozen_r <= 1'b0;
        else if (commit && cmd_r == `SCOC_CMD_OVERLAY && fcur_r == `SCOC_SUB_FREEZE)
            frozen_r <= 1'b1;
    // set overlay rides in sector count; a set can only clear bits
    always_ff @(posedge clk or posedge reset)
        if (reset)
            set_cap_r <= `SCOC_FULL_CAP;
        else if (commit && cmd_r == `SCOC_CMD_OVERLAY && fcur_r == `SCOC_SUB_RESTORE)
            set_cap_r <= `SCOC_FULL_CAP;
        else if (commit && cmd_r == `SCOC_CMD_OVERLAY && fcur_r == `SCOC_SUB_SET)
            set_cap_r <= set_cap_r & count_r;
    assign active_cap = set_cap_r & `SCOC_FULL_CAP;
    // ****************************************************************
    // identify data, full capabilities regardless of set
    // ****************************************************************
    always_comb
    begin
        case (word_r)
            9'h000: word_val = `SCOC_OVL_REV;
            9'h007: word_val = `SCOC_FULL_CAP;
            9'h0FF: word_val = {8'h00 - csum_r - `SCOC_OVL_SIG, `SCOC_OVL_SIG};
            default: word_val = 16'h0000;
        endcase
    end
    always_ff @(posedge clk or posedge reset)
        if (reset)
            csum_r <= 8'h00;
        else if (state_r == SCOC_EXEC)
            csum_r <= 8'h00;
        else if (state_r == SCOC_XFER && bus.data_rd)
            csum_r <= csum_r + word_val[7:0] + word_val[15:8];
    always_ff @(posedge clk or posedge reset)
        if (reset)
            data_r <= 16'h0000;
        else
            data_r <= word_val;
    // ****************************************************************
    // completion limit
    // ****************************************************************
    assign limit_sel = (stream_cmd_completion_time_limit == 32'h0) ? streams_r[stream_cmd_id].completion_time_limit_us
                                                  : stream_cmd_completion_time_limit;
    scoc_completion_time_limit_timer u_timer (
        .clk(clk),
        .reset(reset),
        .start(stream_cmd),
        .stop(stream_cmd_done),
        .limit_us(limit_sel),
        .expired(completion_time_limit_expired)
    );
    assign bus.status = status_r;
    assign bus.error = error_r;
    assign bus.intrq = intrq_r;
    assign bus.data = data_r;
endmodule

//--- hw/scoc_host.sv
// host end: issues commands over the task file and collects results
`timescale 1ns/1ns
`include "scoc_params.svh"
module scoc_host
    import scoc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req,
    input wire logic [7:0] req_cmd,
    input wire logic [7:0] req_feat_cur,
    input wire logic [7:0] req_feat_prev,
    input wire logic [15:0] req_count,
    input wire logic req_slave,
    output logic busy,
    output logic done,
    output logic aborted,
    output logic [15:0] rd_data,
    output logic rd_valid,
    scoc_if.host bus
);
    scoc_state_e state_r;
    logic [7:0] cmd_r, fc_r, fp_r, cc_r, cp_r, dh_r;
    logic wr_r, rd_r, done_r, abt_r, rv_r;
    logic [15:0] rdat_r;
    always_ff @(posedge clk or posedge reset)
        if (reset)
        begin
            state_r <= SCOC_IDLE;
            {cmd_r, fc_r, fp_r, cc_r, cp_r, dh_r} <= '0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            done_r <= 1'b0;
            abt_r <= 1'b0;
            rv_r <= 1'b0;
            rdat_r <= 16'h0000;
        end
        else
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            done_r <= 1'b0;
            rv_r <= rd_r;
            if (rd_r)
                rdat_r <= bus.data;
            case (state_r)
                SCOC_IDLE:
                    if (req)
                    begin
                        cmd_r <= req_cmd;
                        fc_r <= req_feat_cur;
                        fp_r <= req_feat_prev;
                        cc_r <= req_count[7:0];
                        cp_r <= req_count[15:8];
                        dh_r <= {3'b111, req_slave, 4'h0};
                        wr_r <= 1'b1;
                        state_r <= SCOC_EXEC;
                    end
                SCOC_EXEC:
                    if (bus.intrq)
                    begin
                        abt_r <= bus.status[`SCOC_ST_ERR];
                        if (bus.status[`SCOC_ST_DRQ])
                            state_r <= SCOC_XFER;
                        else
                        begin
                            done_r <= 1'b1;
                            state_r <= SCOC_IDLE;
                        end
                    end
                SCOC_XFER:
                    if (!bus.status[`SCOC_ST_DRQ])
                    begin
                        done_r <= 1'b1;
                        state_r <= SCOC_IDLE;
                    end
                    else if (!rd_r)
                        rd_r <= 1'b1;
                default:
                    state_r <= SCOC_IDLE;
            endcase
        end
    assign bus.cmd_wr = wr_r;
    assign bus.command = cmd_r;
    assign bus.feat_cur = fc_r;
    assign bus.feat_prev = fp_r;
    assign bus.count_cur = cc_r;
    assign bus.count_prev = cp_r;
    assign bus.dev_head = dh_r;
    assign bus.data_rd = rd_r;
    assign busy = state_r != SCOC_IDLE;
    assign done = done_r;
    assign aborted = abt_r;
    assign rd_data = rdat_r;
    assign rd_valid = rv_r;
endmodule

//--- dv/scoc_link_props.sv
// concurrent checks on the task-file link between host and drive
`timescale 1ns/1ns
`include "scoc_params.svh"
module scoc_link_props
    import scoc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_n,
    input wire logic dev_is_slave,
    input wire logic cmd_wr,
    input wire logic [7:0] command,
    input wire logic [7:0] feat_cur,
    input wire logic [7:0] dev_head,
    input wire logic [7:0] status,
    input wire logic [7:0] error,
    input wire logic intrq,
    input wire logic data_rd
);
    // ****************************************
    // helper state
    // ****************************************
    logic take;
    logic ovl;
    logic [7:0] last_cmd_r;
    logic [7:0] last_feat_r;
    logic frozen_r;
    logic [9:0] word_cnt_r;
    assign take = cmd_wr && dev_head[`SCOC_DEV_SEL_BIT] == dev_is_slave
        && !status[`SCOC_ST_BSY] && !status[`SCOC_ST_DRQ];
    assign ovl = take && command == `SCOC_CMD_OVERLAY;
    always_ff @(posedge clk)
    begin
        if (take)
        begin
            last_cmd_r <= command;
            last_feat_r <= feat_cur;
        end
    end
    // no reset here: the lock must outlive resets
    always_ff @(posedge clk)
    begin
        if (!power_on_n)
            frozen_r <= 1'b0;
        else if (intrq && !status[0] && last_cmd_r == `SCOC_CMD_OVERLAY
            && last_feat_r == `SCOC_SUB_FREEZE)
            frozen_r <= 1'b1;
    end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            word_cnt_r <= 10'h000;
        else if (take)
            word_cnt_r <= 10'h000;
        else if (data_rd && status[`SCOC_ST_DRQ])
            word_cnt_r <= word_cnt_r + 10'h001;
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_cmd_goes_busy: assert property (take |=> status == 8'h80)
        else $error("busy status missing after command");
    a_intrq_two_cycles: assert property (take |-> ##2 intrq)
        else $error("completion interrupt late or missing");
    a_intrq_one_cycle: assert property (intrq |=> !intrq)
        else $error("interrupt longer than one cycle");
    a_unselected_silent: assert property (
        cmd_wr && dev_head[`SCOC_DEV_SEL_BIT] != dev_is_slave |=> !intrq [*2])
        else $error("unselected drive answered");
    a_reserved_aborts: assert property (
        ovl && (feat_cur & 8'hFC) != 8'hC0 |-> ##2 (intrq && status[0] && error[2]))
        else $error("reserved overlay feature not aborted");
    a_frozen_aborts: assert property (
        ovl && frozen_r |-> ##2 (intrq && status[0] && error[2]))
        else $error("overlay command accepted while locked");
    a_ident_data_ready: assert property (
        ovl && feat_cur == `SCOC_SUB_IDENT && frozen_r == 1'b0
        |-> ##2 (intrq && status[`SCOC_ST_DRQ] && !status[0]))
        else $error("overlay identify without data request");
    a_ident_length: assert property ($fell(status[`SCOC_ST_DRQ]) |-> word_cnt_r == 10'h100)
        else $error("identify block not 256 words");
    a_error_stands: assert property (!cmd_wr && !status[7] |=> $stable(error))
        else $error("error register changed without command");
    a_abort_flags: assert property (intrq && status[0] |-> error[`SCOC_ERR_ABORT])
        else $error("error status without abort bit");
endmodule

//--- dv/stream_config_and_overlay_cmds_tb.sv
// self-checking bench for both ends of the command link
`timescale 1ns/1ns
`include "scoc_params.svh"
module stream_config_and_overlay_cmds_tb;
    // ****************************************
    // stimulus and harness
    // ****************************************
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic power_on_n = 1'b0;
    logic dev_is_slave = 1'b0;
    logic stream_cmd = 1'b0;
    logic [2:0] stream_cmd_id = 3'h0;
    logic [31:0] stream_cmd_completion_time_limit = 32'h0;
    logic stream_cmd_done = 1'b0;
    logic req = 1'b0;
    logic [7:0] req_cmd = 8'h00;
    logic [7:0] req_feat_cur = 8'h00;
    logic [7:0] req_feat_prev = 8'h00;
    logic [15:0] req_count = 16'h0000;
    logic req_slave = 1'b0;
    logic busy, done, aborted, rd_valid, completion_time_limit_expired;
    logic [15:0] rd_data, active_cap, alloc_unit;
    logic [7:0] stream_valid, stream_is_write;
    logic [15:0] words [0:255];
    logic [7:0] rsv [0:3] = '{8'h00, 8'hA0, 8'hC4, 8'hFF};
    int n_errors = 0;
    int total_checks = 0;
    int n_words = 0;
    always #10 clk = ~clk;
    scoc_if i_scoc_if ();
    scoc_host i_scoc_host (.clk(clk), .reset(reset), .req(req), .req_cmd(req_cmd),
        .req_feat_cur(req_feat_cur), .req_feat_prev(req_feat_prev), .req_count(req_count),
        .req_slave(req_slave), .busy(busy), .done(done), .aborted(aborted),
        .rd_data(rd_data), .rd_valid(rd_valid), .bus(i_scoc_if.host));
    scoc_drive i_scoc_drive (.clk(clk), .reset(reset), .power_on_n(power_on_n),
        .dev_is_slave(dev_is_slave), .stream_cmd(stream_cmd), .stream_cmd_id(stream_cmd_id),
        .stream_cmd_completion_time_limit(stream_cmd_completion_time_limit), .stream_cmd_done(stream_cmd_done),
        .bus(i_scoc_if.dev), .active_cap(active_cap), .stream_valid(stream_valid),
        .stream_is_write(stream_is_write), .alloc_unit(alloc_unit),
        .completion_time_limit_expired(completion_time_limit_expired));
    scoc_link_props i_scoc_link_props (.clk(clk), .reset(reset), .power_on_n(power_on_n),
        .dev_is_slave(dev_is_slave), .cmd_wr(i_scoc_if.cmd_wr), .command(i_scoc_if.command),
        .feat_cur(i_scoc_if.feat_cur), .dev_head(i_scoc_if.dev_head),
        .status(i_scoc_if.status), .error(i_scoc_if.error), .intrq(i_scoc_if.intrq),
        .data_rd(i_scoc_if.data_rd));
    always @(posedge clk)
    begin
        if (req === 1'b1)
            n_words <= 0;
        else if (rd_valid === 1'b1)
        begin
            if (n_words < 256)
                words[n_words] <= rd_data;
            n_words <= n_words + 1;
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task send(input logic [7:0] cmd, input logic [7:0] fc, input logic [15:0] cnt);
        @(posedge clk);
        req <= 1'b1;
        req_cmd <= cmd;
        req_feat_cur <= fc;
        req_feat_prev <= 8'h02;
        req_count <= cnt;
        @(posedge clk);
        req <= 1'b0;
    endtask
    task run_cmd(input logic [7:0] cmd, input logic [7:0] fc, input logic [15:0] cnt,
        input logic ab);
        int i;
        i = 0;
        send(cmd, fc, cnt);
        do
        begin
            @(posedge clk);
            #1;
            i++;
        end
        while (done !== 1'b1 && i < 2000);
        // a hung command ends the run here
        if (i >= 2000)
        begin
            check(16'h0000, 16'h0001);
            give_verdict();
        end
        else
            check({15'h0000, aborted}, {15'h0000, ab});
    endtask
    task time_limit(input logic [31:0] us, input int exp);
        int i;
        @(posedge clk);
        stream_cmd <= 1'b1;
        stream_cmd_id <= 3'h5;
        stream_cmd_completion_time_limit <= us;
        @(posedge clk);
        stream_cmd <= 1'b0;
        i = 1;
        do
        begin
            @(posedge clk);
            #1;
            i++;
        end
        while (completion_time_limit_expired !== 1'b1 && i < 4000);
        // a few cycles of slack for the microsecond prescaler phase
        if (i >= 4000)
        begin
            check(i[15:0], exp[15:0]);
            give_verdict();
        end
        else if (i < exp - 3 || i > exp + 3)
            check(i[15:0], exp[15:0]);
        else
            total_checks++;
        @(posedge clk);
        stream_cmd_done <= 1'b1;
        @(posedge clk);
        stream_cmd_done <= 1'b0;
    endtask
    task show_alloc(input logic [2:0] id, input logic [15:0] exp);
        @(posedge clk);
        stream_cmd_id <= id;
        @(posedge clk);
        #1;
        check(alloc_unit, exp);
    endtask
    task pulse_reset;
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
    endtask
    task ident_ok;
        logic [7:0] sum;
        sum = 8'h00;
        run_cmd(`SCOC_CMD_OVERLAY, `SCOC_SUB_IDENT, 16'h0000, 1'b0);
        for (int k = 0; k < 256; k++)
            sum = sum + words[k][7:0] + words[k][15:8];
        check({8'h00, sum}, 16'h0000);
        check(n_words[15:0], 16'h0100);
        check(words[0], `SCOC_OVL_REV);
        check(words[7], `SCOC_FULL_CAP);
        check({8'h00, words[255][7:0]}, {8'h00, `SCOC_OVL_SIG});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        int i;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        power_on_n <= 1'b1;
        run_cmd(`SCOC_CMD_CFG_STREAM, 8'hC5, 16'h1234, 1'b0);
        run_cmd(`SCOC_CMD_CFG_STREAM, 8'h80, 16'h00FF, 1'b0);
        check({8'h00, stream_valid}, 16'h0021);
        check({8'h00, stream_is_write}, 16'h0020);
        show_alloc(3'h5, 16'h1234);
        show_alloc(3'h0, 16'h00FF);
        run_cmd(`SCOC_CMD_CFG_STREAM, 8'h85, 16'hABCD, 1'b0);
        check({8'h00, stream_is_write}, 16'h0000);
        run_cmd(`SCOC_CMD_CFG_STREAM, 8'h03, 16'h5555, 1'b1);
        check({8'h00, stream_valid}, 16'h0021);
        show_alloc(3'h5, 16'hABCD);
        run_cmd(`SCOC_CMD_CFG_STREAM, 8'h00, 16'h0000, 1'b0);
        check({8'h00, stream_valid}, 16'h0020);
        time_limit(32'h0, 2 * `SCOC_TIME_UNIT * `SCOC_US_CYCLES);
        time_limit(32'h3, 3 * `SCOC_US_CYCLES);
        $display("test streams done");
        for (i = 0; i < 4; i++)
            run_cmd(`SCOC_CMD_OVERLAY, rsv[i], 16'h0000, 1'b1);
        check(active_cap, `SCOC_FULL_CAP);
        ident_ok();
        run_cmd(`SCOC_CMD_OVERLAY, `SCOC_SUB_SET, 16'h00F0, 1'b0);
        check(active_cap, 16'h00F0);
        ident_ok();
        run_cmd(`SCOC_CMD_OVERLAY, `SCOC_SUB_RESTORE, 16'h0000, 1'b0);
        check(active_cap, `SCOC_FULL_CAP);
        $display("test overlay done");
        run_cmd(`SCOC_CMD_OVERLAY, `SCOC_SUB_FREEZE, 16'h0000, 1'b0);
        for (i = 0; i < 4; i++)
            run_cmd(`SCOC_CMD_OVERLAY, 8'hC0 + i[7:0], 16'h0000, 1'b1);
        pulse_reset();
        run_cmd(`SCOC_CMD_OVERLAY, `SCOC_SUB_IDENT, 16'h0000, 1'b1);
        @(posedge clk);
        power_on_n <= 1'b0;
        @(posedge clk);
        power_on_n <= 1'b1;
        ident_ok();
        $display("test freeze done");
        @(posedge clk);
        dev_is_slave <= 1'b1;
        req_slave <= 1'b1;
        ident_ok();
        req_slave <= 1'b0;
        send(`SCOC_CMD_OVERLAY, `SCOC_SUB_IDENT, 16'h0000);
        i = 0;
        repeat (20)
        begin
            @(posedge clk);
            #1;
            i += int'(i_scoc_if.intrq !== 1'b0 || done !== 1'b0);
        end
        check(i[15:0], 16'h0000);
        check({15'h0000, busy}, 16'h0001);
        pulse_reset();
        $display("test select done");
        give_verdict();
    end
endmodule
